//--- cia_control_input.sv
// control input acquisition: analog sampling, servo pulses, scaling
// assumes an external 10-bit adc with start/done handshake on core_clk
// and configuration inputs held steady by the host
`timescale 1ns/1ns

module cia_control_input
	import cia_pkg::*;
#(
	parameter int PERIOD_CYC = CTRL_CYC,
	parameter int LOST_CYC   = SERVO_LOST_CYC,
	parameter int RUN_CYC    = SERVO_RUN_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [1:0]  inputMode,
	input  wire logic        forceAnalog,
	input  wire logic        detectDisconnect,
	input  wire logic        pullUpOption,
	input  wire logic [2:0]  sampleLog2,
	input  wire logic        invertInput,
	input  wire logic [2:0]  scaleDegree,
	input  wire logic [11:0] inMin,
	input  wire logic [11:0] inNeutMin,
	input  wire logic [11:0] inNeutMax,
	input  wire logic [11:0] inMax,
	input  wire logic [11:0] tgtMin,
	input  wire logic [11:0] tgtNeut,
	input  wire logic [11:0] tgtMax,
	input  wire logic [11:0] errMin,
	input  wire logic [11:0] errMax,
	input  wire logic        disconnectErrEn,
	input  wire logic        invalidErrEn,
	input  wire logic        adcDone,
	input  wire logic [9:0]  adcData,
	input  wire logic        servo_pulse_pin,
	output logic             adcStart,
	output logic             i2cEnable,
	output logic             pullUpEnable,
	output logic             clockPinOut,
	output logic             clockPinOe_n,
	output logic [15:0]      analogReading,
	output logic [15:0]      servo_pulse_width_value,
	output logic [11:0]      inputValue,
	output logic [11:0]      target,
	output logic             errDisconnect,
	output logic             errInvalid,
	output logic             periodTick
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	cia_state_e  state;
	logic [20:0] periodCount;
	logic        analogSel;
	logic        detectOn;
	logic [2:0]  sampleLog;
	logic [2:0]  shiftAmt;
	logic [6:0]  sampleIdx;
	logic        lastSample;
	logic [15:0] accum;
	logic [15:0] next_accum;
	logic        pullFail;
	logic        outOfWindow;
	logic [15:0] servoWidth;
	logic        servoLost;
	logic        mapDone;
	logic [11:0] mapTarget;

	assign analogSel   = inputMode == MODE_ANALOG || forceAnalog;
	assign detectOn    = detectDisconnect && inputMode == MODE_ANALOG;
	assign sampleLog   = sampleLog2 > SAMPLE_LOG_MAX ? SAMPLE_LOG_MAX
		: sampleLog2;
	assign shiftAmt    = SAMPLE_LOG_MAX - sampleLog;
	assign lastSample  = sampleIdx == 7'((8'h01 << sampleLog) - 8'h01);
	assign next_accum  = accum + {6'h00, adcData};
	assign outOfWindow = inputValue < errMin || inputValue > errMax;

	// control period divider
	always_ff @(posedge core_clk) begin
		if (reset) begin
			periodCount <= 21'h0;
			periodTick  <= 1'b0;
		end else if (periodCount == 21'(PERIOD_CYC - 1)) begin
			periodCount <= 21'h0;
			periodTick  <= 1'b1;
		end else begin
			periodCount <= periodCount + 21'h1;
			periodTick  <= 1'b0;
		end
	end

	// pin configuration follows mode each cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			i2cEnable    <= 1'b1;
			pullUpEnable <= 1'b0;
			clockPinOe_n <= 1'b1;
		end else begin
			i2cEnable    <= !analogSel;
			pullUpEnable <= pullUpOption && analogSel;
			clockPinOe_n <= !detectOn;
		end
	end

	// clock pin low only during the disconnect test conversion
	always_ff @(posedge core_clk) begin
		if (reset)
			clockPinOut <= 1'b1;
		else
			clockPinOut <= !(state == ST_PULL || state == ST_PWAIT);
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			adcStart <= 1'b0;
		else
			adcStart <= state == ST_CONV || state == ST_PULL;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state     <= ST_IDLE;
			sampleIdx <= 7'h00;
			accum     <= 16'h0000;
		end else begin
			case (state)
			ST_IDLE: if (periodTick) begin
				sampleIdx <= 7'h00;
				accum     <= 16'h0000;
				state     <= analogSel ? ST_CONV : ST_EVAL;
			end
			ST_CONV: state <= ST_WAIT;
			ST_WAIT: if (adcDone) begin
				accum     <= next_accum;
				sampleIdx <= sampleIdx + 7'h01;
				if (!lastSample)
					state <= ST_CONV;
				else if (detectOn)
					state <= ST_PULL;
				else
					state <= ST_EVAL;
			end
			ST_PULL: state <= ST_PWAIT;
			ST_PWAIT: if (adcDone)
				state <= ST_EVAL;
			ST_EVAL: state <= ST_MAP;
			ST_MAP: state <= ST_WMAP;
			ST_WMAP: if (mapDone)
				state <= ST_IDLE;
			default: state <= ST_IDLE;
			endcase
		end
	end

	// accumulated reading, normalised to a 65472 full scale
	always_ff @(posedge core_clk) begin
		if (reset)
			analogReading <= 16'h0000;
		else if (state == ST_WAIT && adcDone && lastSample)
			analogReading <= next_accum << shiftAmt;
	end

	// a wired pot follows the pulled-low clock pin down to at most half
	always_ff @(posedge core_clk) begin
		if (reset)
			pullFail <= 1'b0;
		else if (state == ST_IDLE && periodTick)
			pullFail <= 1'b0;
		else if (state == ST_PWAIT && adcDone)
			pullFail <= {adcData, 1'b0} > {1'b0, analogReading[15:6]};
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			servo_pulse_width_value <= 16'h0000;
		else
			servo_pulse_width_value <= servoWidth;
	end

	// other modes keep the last input value; widths stay below 32768
	always_ff @(posedge core_clk) begin
		if (reset)
			inputValue <= 12'h000;
		else if (state == ST_EVAL && inputMode == MODE_ANALOG)
			inputValue <= analogReading[15:4];
		else if (state == ST_EVAL && inputMode == MODE_SERVO)
			inputValue <= servoWidth[14:3];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			errDisconnect <= 1'b0;
			errInvalid    <= 1'b0;
		end else if (state == ST_MAP) begin
			errDisconnect <= disconnectErrEn
				&& (inputMode == MODE_ANALOG || inputMode == MODE_SERVO)
				&& (outOfWindow || pullFail);
			errInvalid <= invalidErrEn && inputMode == MODE_SERVO
				&& servoLost;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			target <= 12'h000;
		else if (state == ST_WMAP && mapDone)
			target <= mapTarget;
	end

	cia_servo_meter #(
		.LOST_CYC (LOST_CYC),
		.RUN_CYC  (RUN_CYC)
	) uServo (
		.core_clk      (core_clk),
		.reset         (reset),
		.servoPulsePin (servo_pulse_pin),
		.pulseWidth    (servoWidth),
		.lost          (servoLost)
	);

	cia_scale_map uMap (
		.core_clk  (core_clk),
		.reset     (reset),
		.start     (state == ST_MAP),
		.inVal     (inputValue),
		.inMin     (inMin),
		.inNeutMin (inNeutMin),
		.inNeutMax (inNeutMax),
		.inMax     (inMax),
		.tgtMin    (tgtMin),
		.tgtNeut   (tgtNeut),
		.tgtMax    (tgtMax),
		.invert    (invertInput),
		.degree    (scaleDegree),
		.done      (mapDone),
		.target    (mapTarget)
	);

	sequence sqSamplesDone;
		state == ST_WAIT && adcDone && lastSample;
	endsequence

	sequence sqPullTest;
		state == ST_PULL ##1 state == ST_PWAIT && adcStart && !clockPinOut;
	endsequence

	chk_i2c_off: assert property (analogSel |=> !i2cEnable)
		else $error("i2c left enabled in analog mode");
	chk_sample_end: assert property (sqSamplesDone
		|=> state == ST_PULL || state == ST_EVAL)
		else $error("sampling did not end on last conversion");
	chk_read_max: assert property (analogReading <= READ_MAX)
		else $error("accumulated reading above full scale");
	chk_analog_input: assert property ((state == ST_EVAL
		&& inputMode == MODE_ANALOG) |=> inputValue == analogReading[15:4])
		else $error("analog input value not reading over 16");
	// detect must already be on at the last sample, where the branch is taken
	chk_pull_low: assert property ((sqSamplesDone ##0 detectOn)
		|=> sqPullTest)
		else $error("clock pin not pulled low for disconnect test");
	chk_scl_idle: assert property (!clockPinOut
		|-> $past(state) == ST_PULL || $past(state) == ST_PWAIT)
		else $error("clock pin low outside the test");
	chk_pullup_opt: assert property (!pullUpOption |=> !pullUpEnable)
		else $error("pull-up enabled without option");
	chk_servo_input: assert property ((state == ST_EVAL
		&& inputMode == MODE_SERVO) |=> inputValue == servoWidth[14:3])
		else $error("servo input value not width over 8");
	chk_invalid_err: assert property ((state == ST_MAP
		&& invalidErrEn && inputMode == MODE_SERVO && servoLost)
		|=> errInvalid)
		else $error("lost servo signal not flagged");
	chk_window_err: assert property ((state == ST_MAP
		&& disconnectErrEn && inputMode == MODE_ANALOG && outOfWindow)
		|=> errDisconnect)
		else $error("input outside error window not flagged");
	chk_period_len: assert property (periodTick
		|=> !periodTick [*2])
		else $error("control period ticks too close");

endmodule : cia_control_input

//--- cia_pkg.sv
// constants, state codes and timing for the control input acquire block
// assumes a single 125 MHz core clock

package cia_pkg;

	localparam int CLK_HZ         = 125_000_000;
	localparam int CTRL_PERIOD_MS = 10;
	localparam int CTRL_CYC       = CLK_HZ / 1000 * CTRL_PERIOD_MS;
	localparam int SERVO_LOST_MS  = 100;
	localparam int SERVO_RUN_MS   = 500;
	localparam int SERVO_LOST_CYC = CLK_HZ / 1000 * SERVO_LOST_MS;
	localparam int SERVO_RUN_CYC  = CLK_HZ / 1000 * SERVO_RUN_MS;

	// 1/12 us ticks from 125 MHz: add 12 per cycle, wrap at 125
	localparam logic [7:0] UNIT_STEP = 8'h0c;
	localparam logic [7:0] UNIT_WRAP = 8'h7d;
	localparam int UNIT_PER_US   = 12;
	localparam int PULSE_MIN_US  = 200;
	localparam int PULSE_MAX_US  = 2700;
	localparam logic [15:0] PULSE_MIN = 16'(PULSE_MIN_US * UNIT_PER_US);
	localparam logic [15:0] PULSE_MAX = 16'(PULSE_MAX_US * UNIT_PER_US);
	localparam logic [1:0]  GOOD_RUN  = 2'h3;

	localparam logic [2:0]  SAMPLE_LOG_MAX = 3'h6;
	localparam logic [15:0] READ_MAX       = 16'hffc0;
	localparam logic [2:0]  DEGREE_MAX     = 3'h5;
	localparam int FRAC_BITS = 12;

	typedef enum logic [1:0] {
		MODE_OTHER  = 2'b00,
		MODE_ANALOG = 2'b01,
		MODE_SERVO  = 2'b10
	} cia_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CONV  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_PULL  = 3'b011,
		ST_PWAIT = 3'b100,
		ST_EVAL  = 3'b101,
		ST_MAP   = 3'b110,
		ST_WMAP  = 3'b111
	} cia_state_e;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_DIV  = 2'b01,
		MS_POW  = 2'b10,
		MS_OUT  = 2'b11
	} cia_map_e;

endpackage : cia_pkg

//--- cia_servo_meter.sv
// servo pulse width meter with validity run and signal-loss timeouts
// assumes the pulse pin is already synchronous to core_clk
`timescale 1ns/1ns

module cia_servo_meter
	import cia_pkg::*;
#(
	parameter int LOST_CYC = SERVO_LOST_CYC,
	parameter int RUN_CYC  = SERVO_RUN_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        servoPulsePin,
	output logic [15:0]      pulseWidth,
	output logic             lost
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	logic [7:0]  unitPhase;
	logic        unitTick;
	logic        pinPrev;
	logic [15:0] highCount;
	logic [1:0]  goodRun;
	logic [25:0] sinceGood;
	logic [25:0] sinceRun;
	logic        fall;
	logic        valid;
	logic        store;

	assign fall  = pinPrev && !servoPulsePin;
	assign valid = highCount >= PULSE_MIN && highCount <= PULSE_MAX;
	assign store = fall && valid && goodRun >= 2'h2;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			unitPhase <= 8'h00;
			unitTick  <= 1'b0;
		end else if (unitPhase >= UNIT_WRAP - UNIT_STEP) begin
			unitPhase <= unitPhase + UNIT_STEP - UNIT_WRAP;
			unitTick  <= 1'b1;
		end else begin
			unitPhase <= unitPhase + UNIT_STEP;
			unitTick  <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pinPrev   <= 1'b0;
			highCount <= 16'h0000;
		end else begin
			pinPrev <= servoPulsePin;
			if (servoPulsePin && !pinPrev)
				highCount <= 16'h0000;
			else if (servoPulsePin && unitTick && highCount != 16'hffff)
				highCount <= highCount + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			goodRun <= 2'h0;
		else if (fall)
			goodRun <= !valid ? 2'h0 :
				(goodRun == GOOD_RUN ? GOOD_RUN : goodRun + 2'h1);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sinceGood <= 26'h0;
			sinceRun  <= 26'h0;
		end else begin
			if (fall && valid)
				sinceGood <= 26'h0;
			else if (sinceGood != 26'(LOST_CYC))
				sinceGood <= sinceGood + 26'h1;
			if (store)
				sinceRun <= 26'h0;
			else if (sinceRun != 26'(RUN_CYC))
				sinceRun <= sinceRun + 26'h1;
		end
	end

	// a fresh store wins pulseWidth over a timeout landing in the same cycle; lost still follows the loss timeout
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pulseWidth <= 16'h0000;
			lost       <= 1'b0;
		end else begin
			lost <= sinceGood == 26'(LOST_CYC);
			if (store)
				pulseWidth <= highCount;
			else if (sinceGood == 26'(LOST_CYC))
				pulseWidth <= 16'h0000;
			else if (sinceRun == 26'(RUN_CYC))
				pulseWidth <= 16'h0000;
		end
	end

	chk_store_width: assert property (store
		|=> pulseWidth == $past(highCount))
		else $error("pulse width not stored after valid run");
	// lost is checked with the clear: a valid fall may end the loss at once
	chk_lost_clear: assert property ((sinceGood == 26'(LOST_CYC)
		&& !store) |=> pulseWidth == 16'h0000 && lost)
		else $error("width not cleared on signal loss");
	chk_run_clear: assert property ((sinceRun == 26'(RUN_CYC)
		&& !store) |=> pulseWidth == 16'h0000)
		else $error("width not cleared after run timeout");

endmodule : cia_servo_meter

//--- cia_scale_map.sv
// piecewise polynomial mapping of input value to target
// assumes start is a one-cycle pulse and inputs are held while busy
`timescale 1ns/1ns

module cia_scale_map
	import cia_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        start,
	input  wire logic [11:0] inVal,
	input  wire logic [11:0] inMin,
	input  wire logic [11:0] inNeutMin,
	input  wire logic [11:0] inNeutMax,
	input  wire logic [11:0] inMax,
	input  wire logic [11:0] tgtMin,
	input  wire logic [11:0] tgtNeut,
	input  wire logic [11:0] tgtMax,
	input  wire logic        invert,
	input  wire logic [2:0]  degree,
	output logic             done,
	output logic [11:0]      target
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	cia_map_e    state;
	logic [11:0] hiT;
	logic [11:0] loT;
	logic [11:0] den;
	logic [11:0] endT;
	logic [12:0] rem;
	logic [12:0] remShift;
	logic [11:0] quo;
	logic [11:0] pw;
	logic [23:0] pwProd;
	logic [3:0]  stepCnt;
	logic [2:0]  powLeft;
	logic signed [12:0] delta;
	logic signed [25:0] offs;
	logic signed [13:0] sum;

	assign hiT      = invert ? tgtMin : tgtMax;
	assign loT      = invert ? tgtMax : tgtMin;
	assign remShift = {rem[11:0], 1'b0};
	assign pwProd   = pw * quo;
	assign delta    = $signed({1'b0, endT}) - $signed({1'b0, tgtNeut});
	assign offs     = delta * $signed({1'b0, pw});
	assign sum      = $signed({2'b00, tgtNeut}) + 14'(offs >>> FRAC_BITS);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state   <= MS_IDLE;
			done    <= 1'b0;
			target  <= 12'h000;
			den     <= 12'h000;
			endT    <= 12'h000;
			rem     <= 13'h0000;
			quo     <= 12'h000;
			pw      <= 12'h000;
			stepCnt <= 4'h0;
			powLeft <= 3'h0;
		end else begin
			done <= 1'b0;
			case (state)
			MS_IDLE: if (start) begin
				stepCnt <= 4'h0;
				quo     <= 12'h000;
				powLeft <= (degree == 3'h0) ? 3'h0 :
					(degree > DEGREE_MAX ? DEGREE_MAX : degree) - 3'h1;
				if (inVal >= inMax) begin
					target <= hiT;
					done   <= 1'b1;
				end else if (inVal <= inMin) begin
					target <= loT;
					done   <= 1'b1;
				end else if (inVal > inNeutMax) begin
					rem   <= {1'b0, inVal - inNeutMax};
					den   <= inMax - inNeutMax;
					endT  <= hiT;
					state <= MS_DIV;
				end else if (inVal < inNeutMin) begin
					rem   <= {1'b0, inNeutMin - inVal};
					den   <= inNeutMin - inMin;
					endT  <= loT;
					state <= MS_DIV;
				end else begin
					target <= tgtNeut;
					done   <= 1'b1;
				end
			end
			// fractional distance from neutral, 12 fraction bits
			MS_DIV: begin
				if (remShift >= {1'b0, den}) begin
					rem <= remShift - {1'b0, den};
					quo <= {quo[10:0], 1'b1};
				end else begin
					rem <= remShift;
					quo <= {quo[10:0], 1'b0};
				end
				stepCnt <= stepCnt + 4'h1;
				if (stepCnt == 4'(FRAC_BITS - 1))
					state <= MS_POW;
			end
			MS_POW: begin
				if (stepCnt == 4'(FRAC_BITS)) begin
					pw      <= quo;
					stepCnt <= 4'h0;
				end else if (powLeft != 3'h0) begin
					pw      <= pwProd[23:12];
					powLeft <= powLeft - 3'h1;
				end else
					state <= MS_OUT;
			end
			MS_OUT: begin
				target <= sum[11:0];
				done   <= 1'b1;
				state  <= MS_IDLE;
			end
			default: state <= MS_IDLE;
			endcase
		end
	end

	chk_clamp_high: assert property ((state == MS_IDLE && start
		&& inVal >= inMax) |=> done && target == $past(hiT))
		else $error("input above maximum not clamped");
	chk_invert_swap: assert property ((state == MS_IDLE && start
		&& invert && inVal <= inMin && inVal < inMax)
		|=> target == $past(tgtMax))
		else $error("inverted minimum not mapped to target maximum");

endmodule : cia_scale_map

//--- cia_pot_model.sv
// potentiometer plus 10-bit adc answering the block's conversion requests
// assumes adcStart is a one-cycle pulse on core_clk
`timescale 1ns/1ns

module cia_pot_model
	import cia_pkg::*;
#(
	parameter int LAT = 3
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       adcStart,
	input  wire logic       clockPinOut,
	input  wire logic       clockPinOe_n,
	input  wire logic [9:0] level,
	input  wire logic       broken,
	output logic            adcDone,
	output logic [9:0]      adcData
);
	int   cnt;
	logic pinLow;

	// a wired pot sags well below half while its supply pin is pulled low
	assign pinLow = !clockPinOut && !clockPinOe_n;

	always_ff @(posedge core_clk) begin
		adcDone <= 1'b0;
		// data is meaningless outside done, so keep it moving
		adcData <= adcData ^ 10'h3ff;
		if (reset) begin
			cnt <= 0;
			adcData <= 10'h155;
		end else if (adcStart) begin
			cnt <= LAT;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				adcDone <= 1'b1;
				adcData <= (pinLow && !broken) ? level >> 2 : level;
			end
		end
	end
endmodule : cia_pot_model

//--- cia_control_input_bench.sv
// self-checking bench for cia_control_input with adc and servo stand-ins
// assumes shortened period and timeout parameters set below
`timescale 1ns/1ns

module cia_control_input_bench;
	import cia_pkg::*;
	localparam int PER = 500;
	localparam int LOSTC = 26000;
	logic core_clk = 1'b0, reset = 1'b1, servoPin = 1'b0, broken = 1'b0;
	logic [1:0] inputMode = MODE_OTHER;
	logic forceAnalog = 0, detectDisconnect = 0, pullUpOption = 0;
	logic invertInput = 0, disconnectErrEn = 0, invalidErrEn = 0;
	logic [2:0] sampleLog2 = 3'h0, scaleDegree = 3'h1;
	logic [11:0] errMin = 12'h000, errMax = 12'hfff;
	logic [11:0] tgtMin = 12'h400, tgtNeut = 12'h800, tgtMax = 12'hc00;
	logic [9:0] level = 10'h000, adcData;
	logic adcDone, adcStart, i2cEnable, pullUpEnable, clockPinOut;
	logic clockPinOe_n, errDisconnect, errInvalid, periodTick;
	logic [15:0] analogReading, width;
	logic [11:0] inputValue, target;
	logic [31:0] seed = 32'h3e;
	int errorCnt = 0, checkCount = 0, cyc = 0, falls = 0, d;

	always #4 core_clk = ~core_clk;

	cia_control_input #(.PERIOD_CYC(PER), .LOST_CYC(LOSTC),
		.RUN_CYC(80000)) u_dut (.core_clk(core_clk), .reset(reset),
		.inputMode(inputMode), .forceAnalog(forceAnalog),
		.detectDisconnect(detectDisconnect), .pullUpOption(pullUpOption),
		.sampleLog2(sampleLog2), .invertInput(invertInput),
		.scaleDegree(scaleDegree), .inMin(12'h400), .inNeutMin(12'h7d0),
		.inNeutMax(12'h800), .inMax(12'hc00), .tgtMin(tgtMin),
		.tgtNeut(tgtNeut), .tgtMax(tgtMax), .errMin(errMin),
		.errMax(errMax), .disconnectErrEn(disconnectErrEn),
		.invalidErrEn(invalidErrEn), .adcDone(adcDone), .adcData(adcData),
		.servo_pulse_pin(servoPin), .adcStart(adcStart),
		.i2cEnable(i2cEnable), .pullUpEnable(pullUpEnable),
		.clockPinOut(clockPinOut), .clockPinOe_n(clockPinOe_n),
		.analogReading(analogReading), .servo_pulse_width_value(width),
		.inputValue(inputValue), .target(target),
		.errDisconnect(errDisconnect), .errInvalid(errInvalid),
		.periodTick(periodTick));

	cia_pot_model u_pot (.core_clk(core_clk), .reset(reset),
		.adcStart(adcStart), .clockPinOut(clockPinOut),
		.clockPinOe_n(clockPinOe_n), .level(level), .broken(broken),
		.adcDone(adcDone), .adcData(adcData));

	always @(negedge clockPinOut) falls++;

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 115000) begin
			errorCnt++;
			endOfTest();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// piecewise mapping, real arithmetic; the design truncates a little
	function automatic int expTgt(input int x, input bit inv, input int n);
		int hi, lo, nt;
		real f;
		hi = inv ? tgtMin : tgtMax;
		lo = inv ? tgtMax : tgtMin;
		nt = tgtNeut;
		if (x > 3072) return hi;
		if (x < 1024) return lo;
		if (x >= 2000 && x <= 2048) return nt;
		if (x > 2048) begin
			f = real'(x - 2048) / 1024.0;
			return nt + int'((hi - nt) * f ** n);
		end
		f = real'(2000 - x) / 976.0;
		return nt - int'((nt - lo) * f ** n);
	endfunction : expTgt

	task automatic chk(input string nm, input int e, input logic [15:0] g,
		input int tol = 0);
		checkCount++;
		if ($isunknown(g) || int'(g) > e + tol || int'(g) < e - tol) begin
			errorCnt++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk

	task automatic ticks(input int n);
		repeat (n) @(posedge periodTick);
		@(negedge core_clk);
	endtask : ticks

	task automatic cyc2();
		repeat (2) @(negedge core_clk);
	endtask : cyc2

	// servo source idles low between high pulses
	task automatic pulse(input int c);
		servoPin = 1'b1;
		repeat (c) @(negedge core_clk);
		servoPin = 1'b0;
		repeat (100) @(negedge core_clk);
	endtask : pulse

	task automatic endOfTest();
		$display("checks %0d errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : endOfTest

	initial begin
		repeat (10) @(negedge core_clk);
		reset = 1'b0;
		chk("i2cEnable", 1, i2cEnable);
		forceAnalog = 1'b1;
		cyc2();
		chk("i2cEnable", 0, i2cEnable);
		chk("pullUpEnable", 0, pullUpEnable);
		pullUpOption = 1'b1;
		cyc2();
		chk("pullUpEnable", 1, pullUpEnable);
		forceAnalog = 1'b0;
		cyc2();
		chk("i2cEnable", 1, i2cEnable);
		chk("pullUpEnable", 0, pullUpEnable);
		inputMode = MODE_ANALOG;
		// servo pulses run beside the analog checks to keep the run short;
		// 25100 cycles is 2409.6 units, just inside the valid window
		fork
			begin
				pulse(100);
				pulse(25100);
				pulse(25100);
			end
		join_none
		// quarter-way cases for every degree, clamp corners, random ones
		for (int i = 0; i < 14; i++) begin
			seed = xs(seed);
			level = i < 10 ? 10'h240 : i == 10 ? 10'h0c0
				: i == 11 ? 10'h3ff : seed[9:0];
			scaleDegree = i < 10 ? 3'(i % 5 + 1) : seed[12:10];
			invertInput = i < 10 ? i / 5 : i == 10 ? 1'b1 : seed[13];
			tgtMax = i == 11 ? 12'hfff : 12'hc00;
			sampleLog2 = 3'(i);
			d = scaleDegree == 0 ? 1 : scaleDegree > 5 ? 5 : scaleDegree;
			ticks(2);
			chk("analogReading", level * 64, analogReading);
			chk("inputValue", level * 4, inputValue);
			chk("target", expTgt(level * 4, invertInput, d), target, 3);
		end
		level = 10'h258;
		detectDisconnect = 1'b1;
		disconnectErrEn = 1'b1;
		ticks(1);
		falls = 0;
		chk("clockPinOe_n", 0, clockPinOe_n);
		ticks(1);
		chk("clock pin lows", 1, 16'(falls));
		chk("errDisconnect", 0, errDisconnect);
		broken = 1'b1;
		ticks(2);
		chk("errDisconnect", 1, errDisconnect);
		disconnectErrEn = 1'b0;
		ticks(2);
		chk("errDisconnect", 0, errDisconnect);
		broken = 1'b0;
		detectDisconnect = 1'b0;
		disconnectErrEn = 1'b1;
		errMin = 12'h961;
		ticks(2);
		chk("errDisconnect", 1, errDisconnect);
		errMin = 12'h000;
		ticks(2);
		chk("errDisconnect", 0, errDisconnect);
		inputMode = MODE_SERVO;
		invalidErrEn = 1'b1;
		wait fork;
		chk("servo width", 0, width);
		pulse(25100);
		chk("servo width", 2409, width, 2);
		ticks(2);
		chk("inputValue", 301, inputValue, 1);
		chk("errInvalid", 0, errInvalid);
		repeat (LOSTC) @(negedge core_clk);
		chk("servo width", 0, width);
		ticks(2);
		chk("errInvalid", 1, errInvalid);
		endOfTest();
	end
endmodule : cia_control_input_bench
